// [rtl/jds_jet_drop_sequencer.sv]
// jet drop sequencer top: recipes, drop timing, idle timers, avalon slave
`timescale 1ns/1ps
module jds_jet_drop_sequencer (
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_b_i,
	input  wire logic [jds_pkg::ADDR_W-1:0]   avs_address_i,
	input  wire logic                         avs_read_i,
	input  wire logic                         avs_write_i,
	input  wire logic [jds_pkg::DATA_W-1:0]   avs_writedata_i,
	output logic      [jds_pkg::DATA_W-1:0]   avs_readdata_o,
	output logic                              avs_waitrequest_o,
	input  wire logic [jds_pkg::NUM_RCP-1:0]  trig_b_i,
	output logic                              jet_drive_o,
	output logic                              jet_active_indicator_b_o,
	output logic                              jet_valve_closed_o,
	output logic                              heater_en_o,
	output logic      [1:0]                   ser_baud_sel_o,
	output logic      [1:0]                   ser_parity_o,
	output logic                              ser_seven_bit_o,
	output logic                              ser_cts_en_o
);
	import jds_pkg::*;

	// ************************************************************
	// storage
	// ************************************************************
	logic [TIME_W-1:0] rcp_refill  [NUM_RCP];
	logic [TIME_W-1:0] rcp_dwell   [NUM_RCP];
	logic [TIME_W-1:0] rcp_plus    [NUM_RCP];
	logic [TIME_W-1:0] rcp_xtra    [NUM_RCP];
	logic [TIME_W-1:0] rcp_idle_s  [NUM_RCP];
	logic [TIME_W-1:0] rcp_count   [NUM_RCP];
	logic              rcp_mode    [NUM_RCP];
	logic [7:0]        htr_min;
	logic              htr_on;
	logic [5:0]        ser_cfg;

	jds_state_t        state;
	jds_state_t        next_state;
	logic [2:0]        cur_idx;
	logic              run_level;
	logic [TIME_W-1:0] drops_left;
	logic [TIME_W-1:0] drops_done;
	logic [LEN_W-1:0]  phase_len;
	logic [LEN_W-1:0]  ph_cnt;
	logic [11:0]       pre_cnt;
	logic [13:0]       idle_step;
	logic [TIME_W-1:0] idle_sec;
	logic [5:0]        min_sec;
	logic [7:0]        idle_min;
	logic [DATA_W-1:0] rd_mux;

	// ************************************************************
	// trigger inputs
	// ************************************************************
	logic [NUM_RCP-1:0] trig_fell;
	logic [NUM_RCP-1:0] trig_low;

	// one detector per recipe input
	genvar g;
	generate
		for (g = 0; g < NUM_RCP; g++) begin : g_trig
			jds_trig_edge u_edge (
				.ref_clk_i (ref_clk_i),
				.rst_b_i   (rst_b_i),
				.trig_b_i  (trig_b_i[g]),
				.fell_o    (trig_fell[g]),
				.low_o     (trig_low[g])
			);
		end
	endgenerate

	// ************************************************************
	// bus decode
	// ************************************************************
	wire             wr_en    = avs_write_i & ~avs_waitrequest_o;
	wire       [2:0] rcp_sel  = avs_address_i[7:5];
	wire       [2:0] rcp_fld  = avs_address_i[4:2];
	wire             rcp_hit  = (avs_address_i[9:8] == RCP_PAGE) && (rcp_sel < NUM_RCP_IX);
	wire             ctrl_wr  = wr_en && (avs_address_i == OFF_CTRL);
	wire       [2:0] go_sel   = avs_writedata_i[CTRL_SEL_LO+:3];
	wire             go_req   = ctrl_wr && avs_writedata_i[CTRL_GO] && (go_sel < NUM_RCP_IX);
	wire             heater_cut = (htr_min != 8'h00) && (idle_min >= htr_min);

	// ************************************************************
	// start selection: lowest trigger wins, manual go last
	// ************************************************************
	logic       start_hit;
	logic [2:0] start_idx;
	logic       start_go;
	always_comb begin
		start_hit = 1'b0;
		start_idx = 3'h0;
		start_go  = 1'b0;
		for (int i = NUM_RCP - 1; i >= 0; i--) begin
			if (trig_fell[i]) begin
				start_hit = 1'b1;
				start_idx = 3'(i);
			end
		end
		if (!start_hit && go_req) begin
			start_hit = 1'b1;
			start_idx = go_sel;
			start_go  = 1'b1;
		end
	end

	// ************************************************************
	// drop timing
	// ************************************************************
	wire             in_idle   = (state == ST_IDLE);
	wire       [2:0] run_idx   = in_idle ? start_idx : cur_idx;
	// a manual go has no level to hold, so it always runs the count
	wire             lvl_now   = in_idle ? (rcp_mode[start_idx] == MODE_LEVEL) & ~start_go : run_level;
	wire             idle_long = idle_sec > rcp_idle_s[run_idx];
	wire [LEN_W-1:0] plus_add  = (in_idle || !lvl_now) ? {2'h0, rcp_plus[run_idx]} : '0;
	wire [LEN_W-1:0] xtra_add  = (in_idle && idle_long) ? {2'h0, rcp_xtra[run_idx]} : '0;
	wire [LEN_W-1:0] refill_len = {2'h0, rcp_refill[run_idx]} + plus_add + xtra_add;
	wire             start_ok  = start_hit && (lvl_now || rcp_count[start_idx] != '0);
	wire             step      = (pre_cnt == STEP_CYC - 12'h001);
	// ends on the step that completes the last unit, so a phase is exactly len steps
	wire             phase_done = (phase_len == '0) || (step && (ph_cnt == phase_len - 18'h00001));
	// level keeps going while its input is low; count is not looked at
	wire             more      = run_level ? trig_low[cur_idx] : (drops_left != 16'h0001);

	// next state of the drop sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (start_ok) begin
					next_state = ST_REFILL;
				end
			end
			ST_REFILL: begin
				if (phase_done) begin
					next_state = ST_DWELL;
				end
			end
			ST_DWELL: begin
				if (phase_done) begin
					next_state = more ? ST_REFILL : ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	wire phase_chg = (next_state != state);

	// state register; trigger edges outside idle are never looked at, only a level run reads its input low
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// phase length load: refill total on every refill entry, dwell after
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_len <= '0;
		end else if (phase_chg && next_state == ST_REFILL) begin
			phase_len <= refill_len;
		end else if (phase_chg && next_state == ST_DWELL) begin
			phase_len <= {2'h0, rcp_dwell[cur_idx]};
		end
	end

	// step prescaler and phase counter restart on every phase change
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_cnt <= '0;
			ph_cnt  <= '0;
		end else if (phase_chg) begin
			pre_cnt <= '0;
			ph_cnt  <= '0;
		end else begin
			pre_cnt <= step ? 12'h000 : pre_cnt + 12'h001;
			ph_cnt  <= step ? ph_cnt + 18'h00001 : ph_cnt;
		end
	end

	// run bookkeeping latched at start, drop counting at dwell end
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cur_idx    <= 3'h0;
			run_level  <= 1'b0;
			drops_left <= '0;
			drops_done <= '0;
		end else if (in_idle && start_ok) begin
			cur_idx    <= start_idx;
			run_level  <= lvl_now;
			drops_left <= rcp_count[start_idx];
			drops_done <= '0;
		end else if (state == ST_DWELL && phase_done) begin
			drops_left <= drops_left - 16'h0001;
			drops_done <= drops_done + 16'h0001;
		end
	end

	// idle time in seconds and minutes, saturating, cleared by activity
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idle_step <= '0;
			idle_sec  <= '0;
			min_sec   <= '0;
			idle_min  <= '0;
		end else if (!in_idle) begin
			idle_step <= '0;
			idle_sec  <= '0;
			min_sec   <= '0;
			idle_min  <= '0;
		end else if (step && idle_step == STEPS_PER_S - 14'h0001) begin
			idle_step <= '0;
			idle_sec  <= (idle_sec == '1) ? idle_sec : idle_sec + 16'h0001;
			min_sec   <= (min_sec == SEC_PER_MIN - 6'h01) ? 6'h00 : min_sec + 6'h01;
			if (min_sec == SEC_PER_MIN - 6'h01 && idle_min != 8'hff) begin
				idle_min <= idle_min + 8'h01;
			end
		end else if (step) begin
			idle_step <= idle_step + 14'h0001;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	// recipe slots; a download overwrites whatever was held
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int r = 0; r < NUM_RCP; r++) begin
				rcp_refill[r] <= '0;
				rcp_dwell[r]  <= '0;
				rcp_plus[r]   <= '0;
				rcp_xtra[r]   <= '0;
				rcp_idle_s[r] <= '0;
				rcp_count[r]  <= '0;
				rcp_mode[r]   <= 1'b0;
			end
		end else if (wr_en && rcp_hit) begin
			unique case (rcp_fld)
				F_REFILL:    rcp_refill[rcp_sel] <= avs_writedata_i[TIME_W-1:0];
				F_DWELL:     rcp_dwell[rcp_sel]  <= avs_writedata_i[TIME_W-1:0];
				F_PLUS:      rcp_plus[rcp_sel]   <= avs_writedata_i[TIME_W-1:0];
				F_IDLE_XTRA: rcp_xtra[rcp_sel]   <= avs_writedata_i[TIME_W-1:0];
				F_IDLE_SEC:  rcp_idle_s[rcp_sel] <= avs_writedata_i[TIME_W-1:0];
				F_COUNT:     rcp_count[rcp_sel]  <= avs_writedata_i[TIME_W-1:0];
				F_MODE:      rcp_mode[rcp_sel]   <= avs_writedata_i[0];
				default: begin
				end
			endcase
		end
	end

	// global settings; illegal parity code is kept out
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			htr_min <= HTR_MIN_RST;
			htr_on  <= HTR_ON_RST;
			ser_cfg <= SER_RST;
		end else if (wr_en && avs_address_i == OFF_HTR_MIN) begin
			htr_min <= avs_writedata_i[7:0];
		end else if (wr_en && avs_address_i == OFF_HTR_CTRL) begin
			htr_on <= avs_writedata_i[0];
		end else if (wr_en && avs_address_i == OFF_SERIAL && avs_writedata_i[3:2] != PAR_ILLEGAL) begin
			ser_cfg <= avs_writedata_i[5:0];
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_mux = '0;
		if (rcp_hit) begin
			unique case (rcp_fld)
				F_REFILL:    rd_mux[TIME_W-1:0] = rcp_refill[rcp_sel];
				F_DWELL:     rd_mux[TIME_W-1:0] = rcp_dwell[rcp_sel];
				F_PLUS:      rd_mux[TIME_W-1:0] = rcp_plus[rcp_sel];
				F_IDLE_XTRA: rd_mux[TIME_W-1:0] = rcp_xtra[rcp_sel];
				F_IDLE_SEC:  rd_mux[TIME_W-1:0] = rcp_idle_s[rcp_sel];
				F_COUNT:     rd_mux[TIME_W-1:0] = rcp_count[rcp_sel];
				F_MODE:      rd_mux[0]          = rcp_mode[rcp_sel];
				default:     rd_mux             = '0;
			endcase
		end else if (avs_address_i == OFF_CTRL) begin
			rd_mux[CTRL_VALVE] = ~jet_valve_closed_o;
		end else if (avs_address_i == OFF_STATUS) begin
			rd_mux[ST_ACTIVE]        = ~in_idle;
			rd_mux[ST_RCP_LO+:3]     = cur_idx;
			rd_mux[ST_HTR_CUT]       = heater_cut;
			rd_mux[ST_VALVE]         = jet_valve_closed_o;
			rd_mux[ST_DROPS_LO+:16]  = drops_done;
		end else if (avs_address_i == OFF_HTR_MIN) begin
			rd_mux[7:0] = htr_min;
		end else if (avs_address_i == OFF_HTR_CTRL) begin
			rd_mux[0] = htr_on;
		end else if (avs_address_i == OFF_SERIAL) begin
			rd_mux[5:0] = ser_cfg;
		end
	end

	// one wait state: data captured while waitrequest drops
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= '0;
		end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o    <= avs_read_i ? rd_mux : avs_readdata_o;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// ************************************************************
	// pin outputs
	// ************************************************************
	// all from flops so the robot never sees decode glitches
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			jet_drive_o              <= 1'b0;
			jet_active_indicator_b_o <= 1'b1;
			jet_valve_closed_o       <= VALVE_RST;
			heater_en_o              <= 1'b0;
		end else begin
			jet_drive_o              <= (next_state == ST_DWELL);
			jet_active_indicator_b_o <= (next_state == ST_IDLE);
			heater_en_o              <= htr_on & ~heater_cut;
			if (ctrl_wr) begin
				jet_valve_closed_o <= ~avs_writedata_i[CTRL_VALVE];
			end
		end
	end

	assign ser_baud_sel_o  = ser_cfg[1:0];
	assign ser_parity_o    = ser_cfg[3:2];
	assign ser_seven_bit_o = ser_cfg[4];
	assign ser_cts_en_o    = ser_cfg[5];

	// ************************************************************
	// checks
	// ************************************************************
	chk_busy_level: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		jet_active_indicator_b_o == (state == ST_IDLE))
		else $error("busy output disagrees with sequencer state");
	chk_pulse_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == ST_DWELL && phase_done && !run_level && drops_left == 16'h0001) |=> in_idle)
		else $error("pulse run did not end at count");
	chk_pulse_full: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == ST_DWELL && phase_done && !run_level && drops_left != 16'h0001) |=> state == ST_REFILL)
		else $error("pulse run stopped early");
	chk_level_run: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == ST_DWELL && phase_done && run_level) |=> (state == ST_REFILL) == $past(trig_low[cur_idx]))
		else $error("level run not following trigger");
	chk_ignore_trig: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!in_idle && !phase_chg) |=> $stable(cur_idx) && $stable(drops_done))
		else $error("trigger disturbed active run");
	chk_refill_dwell: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == ST_REFILL && phase_done) |=> state == ST_DWELL && jet_drive_o)
		else $error("refill not followed by dwell");
	chk_first_extra: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(in_idle && start_ok) |=> phase_len == $past(refill_len) && phase_len >= {2'h0, rcp_refill[cur_idx]})
		else $error("first refill length wrong");
	chk_level_later: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == ST_DWELL && phase_done && run_level && trig_low[cur_idx])
		|=> phase_len == {2'h0, rcp_refill[cur_idx]})
		else $error("level drop after first got extra refill");
	chk_heater_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(htr_min == 8'h00 && htr_on) |=> heater_en_o)
		else $error("heater cut with timer disabled");
	chk_bus_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("bus answer late");

endmodule

// [rtl/jds_pkg.sv]
// constants, register map and state type for the jet drop sequencer
package jds_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int             ADDR_W     = 10;
	localparam int             DATA_W     = 32;
	localparam int             NUM_RCP    = 6;
	localparam logic [2:0]     NUM_RCP_IX = 3'h6;
	localparam int             TIME_W     = 16;
	localparam int             LEN_W      = 18;

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [9:0]     OFF_CTRL     = 10'h000;
	localparam logic [9:0]     OFF_STATUS   = 10'h004;
	localparam logic [9:0]     OFF_HTR_MIN  = 10'h008;
	localparam logic [9:0]     OFF_HTR_CTRL = 10'h00c;
	localparam logic [9:0]     OFF_SERIAL   = 10'h010;
	localparam logic [1:0]     RCP_PAGE     = 2'h1;
	// recipe field index, address bits [4:2] inside a 32-byte recipe slot
	localparam logic [2:0]     F_REFILL     = 3'h0;
	localparam logic [2:0]     F_DWELL      = 3'h1;
	localparam logic [2:0]     F_PLUS       = 3'h2;
	localparam logic [2:0]     F_IDLE_XTRA  = 3'h3;
	localparam logic [2:0]     F_IDLE_SEC   = 3'h4;
	localparam logic [2:0]     F_COUNT      = 3'h5;
	localparam logic [2:0]     F_MODE       = 3'h6;
	localparam logic           MODE_LEVEL   = 1'b1;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int             CTRL_GO      = 0;
	localparam int             CTRL_SEL_LO  = 4;
	localparam int             CTRL_VALVE   = 8;
	localparam int             ST_ACTIVE    = 0;
	localparam int             ST_RCP_LO    = 4;
	localparam int             ST_HTR_CUT   = 8;
	localparam int             ST_VALVE     = 9;
	localparam int             ST_DROPS_LO  = 16;
	localparam logic [7:0]     HTR_MIN_RST  = 8'h00;
	localparam logic           HTR_ON_RST   = 1'b0;
	localparam logic           VALVE_RST    = 1'b1;
	// serial: [1:0] baud 0=57600 1=19200 2=9600 3=4800, [3:2] parity
	// 0 none 1 even 2 odd, [4] seven bit, [5] handshake
	localparam logic [5:0]     SER_RST      = 6'h20;
	localparam logic [1:0]     PAR_ILLEGAL  = 2'h3;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int             CLK_NS       = 40;
	localparam int             STEP_NS      = 100000;
	localparam int             STEP_CYC_I   = (STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [11:0]    STEP_CYC     = 12'(STEP_CYC_I);
	localparam logic [13:0]    STEPS_PER_S  = 14'h2710;
	localparam logic [5:0]     SEC_PER_MIN  = 6'h3c;

	// ************************************************************
	// sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_REFILL = 3'b010,
		ST_DWELL  = 3'b100
	} jds_state_t;

endpackage

// [rtl/jds_trig_edge.sv]
// falling edge and low level detect for one trigger input
`timescale 1ns/1ps
module jds_trig_edge (
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	input  wire logic trig_b_i,
	output logic      fell_o,
	output logic      low_o
);

	logic prev;

	// previous level, idle-high so a low at reset release counts as an edge
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev <= 1'b1;
		end else begin
			prev <= trig_b_i;
		end
	end

	assign fell_o = prev & ~trig_b_i;
	assign low_o  = ~trig_b_i;

endmodule

// [tb/jds_trig_host.sv]
// trigger-driving host model for the jet drop sequencer
`timescale 1ns/1ps
module jds_trig_host (
	input  wire logic        ref_clk_i,
	input  wire logic        busy_b_i,
	input  wire logic        fire_i,
	input  wire logic        eager_i,
	input  wire logic [2:0]  sel_i,
	input  wire logic [15:0] hold_i,
	output logic      [5:0]  trig_b_o
);
	// ************************************************************
	// one low pulse per fire request
	// ************************************************************
	initial trig_b_o = 6'h3f;
	// a polite host waits for idle; eager only when a test wants a refused trigger
	always @(posedge ref_clk_i) begin
		if (fire_i) begin
			while (!eager_i && !busy_b_i) @(posedge ref_clk_i);
			trig_b_o[sel_i] <= 1'b0;
			repeat (hold_i) @(posedge ref_clk_i);
			trig_b_o <= 6'h3f;
		end
	end
endmodule

// [tb/testbench.sv]
// self-checking bench: register bus, triggers, drop counts and busy timing
`timescale 1ns/1ps
module testbench;
	import jds_pkg::*;
	logic ref_clk_i, rst_b_i, rd, wr, fire, eager, drv, busy_b, valve, htr, seven, cts, drv_q;
	logic [9:0]  addr;
	logic [31:0] wdata, rdata, rv;
	logic        waitreq;
	logic [5:0]  trig_b;
	logic [1:0]  baud, par;
	logic [2:0]  tsel;
	logic [15:0] thold;
	logic [5:0]  ser_exp;
	int          fail_count, tests_run, drops, busy_cyc;

	jds_jet_drop_sequencer jds_jet_drop_sequencer_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .trig_b_i(trig_b), .jet_drive_o(drv),
		.jet_active_indicator_b_o(busy_b), .jet_valve_closed_o(valve), .heater_en_o(htr),
		.ser_baud_sel_o(baud), .ser_parity_o(par), .ser_seven_bit_o(seven), .ser_cts_en_o(cts));
	jds_trig_host jds_trig_host_inst (.ref_clk_i(ref_clk_i), .busy_b_i(busy_b), .fire_i(fire),
		.eager_i(eager), .sel_i(tsel), .hold_i(thold), .trig_b_o(trig_b));

	// ************************************************************
	// clock, monitor, watchdog
	// ************************************************************
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// drop pulses and busy-low cycles of the current run
	always @(posedge ref_clk_i) begin
		if (busy_b === 1'b0) busy_cyc++;
		if (drv === 1'b1 && drv_q === 1'b0) drops++;
		drv_q <= drv;
	end
	// whole run is about 66k cycles; past 95k it must be a hang
	initial begin
		repeat (95000) @(posedge ref_clk_i);
		fail_count++;
		print_verdict();
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	// one avalon cycle: hold until waitrequest is sampled low
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		rd <= ~w;
		wr <= w;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		if (n >= 50) check(32'h1, 32'h0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wreg(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	// write one recipe slot
	task automatic set_rcp(input logic [2:0] r, input logic [15:0] rf, input logic [15:0] dw,
		input logic [15:0] pl, input logic [15:0] cnt, input logic md);
		wreg({RCP_PAGE, r, F_REFILL, 2'b00}, {16'h0, rf});
		wreg({RCP_PAGE, r, F_DWELL, 2'b00}, {16'h0, dw});
		wreg({RCP_PAGE, r, F_PLUS, 2'b00}, {16'h0, pl});
		wreg({RCP_PAGE, r, F_COUNT, 2'b00}, {16'h0, cnt});
		wreg({RCP_PAGE, r, F_MODE, 2'b00}, {31'h0, md});
	endtask
	task automatic arm();
		drops = 0;
		busy_cyc = 0;
	endtask
	// bounded wait for a run to begin and to finish
	task automatic wait_run();
		int n;
		n = 0;
		while (busy_b !== 1'b0 && n < 9000) begin
			@(posedge ref_clk_i);
			n++;
		end
		n = 0;
		while (busy_b !== 1'b1 && n < 30000) begin
			@(posedge ref_clk_i);
			n++;
		end
		@(posedge ref_clk_i);
	endtask
	task automatic run(input logic [2:0] r, input logic [15:0] h, input logic e);
		arm();
		@(posedge ref_clk_i);
		tsel <= r;
		thold <= h;
		eager <= e;
		fire <= 1'b1;
		@(posedge ref_clk_i);
		fire <= 1'b0;
		wait_run();
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{rd, wr, fire, eager, drv_q} = 5'h0;
		addr = 10'h000;
		wdata = 32'h0;
		tsel = 3'h0;
		thold = 16'h0;
		fail_count = 0;
		tests_run = 0;
		drops = 0;
		busy_cyc = 0;
		rst_b_i = 1'b0;
		repeat (12) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		check({31'h0, busy_b}, 32'h1);
		check({31'h0, valve}, 32'h1);
		check({26'h0, cts, seven, par, baud}, 32'h20);
		check({31'h0, htr}, 32'h0);
		// every serial code; an illegal parity leaves the old setting
		ser_exp = SER_RST;
		for (int v = 0; v < 64; v++) begin
			wreg(OFF_SERIAL, v);
			if (v[3:2] != PAR_ILLEGAL) ser_exp = v[5:0];
			@(posedge ref_clk_i);
			check({26'h0, cts, seven, par, baud}, {26'h0, ser_exp});
		end
		bus(1'b0, 10'h3fc, 32'h0, rv);
		check(rv, 32'h0);
		bus(1'b0, OFF_STATUS, 32'h0, rv);
		check({31'h0, rv[ST_VALVE]}, 32'h1);
		wreg(OFF_CTRL, 32'h100);
		@(posedge ref_clk_i);
		check({31'h0, valve}, 32'h0);
		wreg(OFF_CTRL, 32'h0);
		@(posedge ref_clk_i);
		check({31'h0, valve}, 32'h1);
		wreg(OFF_HTR_CTRL, 32'h1);
		// heater output is one flop behind the heater-on register
		repeat (2) @(posedge ref_clk_i);
		check({31'h0, htr}, 32'h1);
		// six recipes with distinct settings
		set_rcp(3'h0, 16'h1, 16'h1, 16'h0, 16'h1, 1'b0);
		set_rcp(3'h1, 16'h1, 16'h1, 16'h0, 16'h2, 1'b0);
		set_rcp(3'h2, 16'h1, 16'h1, 16'h0, 16'h3, 1'b0);
		set_rcp(3'h3, 16'h1, 16'h1, 16'h1, 16'h2, 1'b0);
		set_rcp(3'h4, 16'h1, 16'h1, 16'h1, 16'h9, MODE_LEVEL);
		set_rcp(3'h5, 16'h1, 16'h2, 16'h0, 16'h1, 1'b0);
		run(3'h0, 16'h4, 1'b0);
		check(drops, 32'h1);
		check(busy_cyc, 32'd5000);
		run(3'h1, 16'h4, 1'b0);
		check(drops, 32'h2);
		check(busy_cyc, 32'd10000);
		run(3'h3, 16'h4, 1'b0);
		check(busy_cyc, 32'd15000);
		run(3'h5, 16'h4, 1'b0);
		check(busy_cyc, 32'd7500);
		// level: released during the second drop, count nine ignored
		run(3'h4, 16'd9000, 1'b0);
		check(drops, 32'h2);
		// manual start, with a stray trigger while running
		arm();
		wreg(OFF_CTRL, 32'h11);
		repeat (100) @(posedge ref_clk_i);
		tsel <= 3'h0;
		thold <= 16'h4;
		eager <= 1'b1;
		fire <= 1'b1;
		@(posedge ref_clk_i);
		fire <= 1'b0;
		wait_run();
		check(drops, 32'h2);
		// a fresh download replaces the stored count
		wreg({RCP_PAGE, 3'h1, F_COUNT, 2'b00}, 32'h1);
		run(3'h1, 16'h4, 1'b0);
		check(drops, 32'h1);
		print_verdict();
	end
endmodule
